// ==== src/sct_target.sv ====
`include "sct_map.svh"
`default_nettype none
module sct_target
	import sct_pkg::*;
#(
	parameter int ABORT_CYC = `SCT_ABORT_CYC
) (
	// clock and reset
	input  wire logic  clk_i,
	input  wire logic  rst_b_i,
	// bus
	sct_bus_if.tgt     bus,
	// decoded command
	output logic       cmd_valid_o,
	output logic [7:0] cmd_op_o,
	output logic [7:0] cmd_b1_o,
	output logic [23:0] cmd_arg_o,
	output logic       cmd_link_o,
	output logic       cmd_flag_o,
	output logic       cmd_bad_o
);
	typedef enum logic [2:0] {T_IDLE, T_SETTLE, T_REQ, T_ACK, T_STAT, T_STAT_ACK, T_CLEAR} sct_tst_t;
	sct_tst_t   st_q;
	logic [17:0] cnt_q;
	logic [2:0]  idx_q;
	logic [7:0]  cdb_q [0:`SCT_CDB_LEN-1];
	logic        bad;
	logic        bad_q;
	logic        sel_seen;

	// selected: own id bit on the data lines while nobody is busy
	assign sel_seen = bus.sel && !bus.bsy && bus.db[`SCT_TGT_ID];

	function automatic logic op_ok(input logic [7:0] op);
		case (op)
			8'h00, 8'h01, 8'h02, 8'h03, 8'h05,
			8'h08, 8'h0A, 8'h0C, 8'h10, 8'h11: op_ok = 1'b1;
			8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18,
			8'h19, 8'h1A, 8'h1B, 8'h1D, 8'h1E,
			8'h3B, 8'h3C: op_ok = 1'b1;
			default: op_ok = 1'b0;
		endcase
	endfunction

	always_comb begin
		bad = !op_ok(cdb_q[0]);
		bad = bad || (cdb_q[1][`SCT_LUN_MSB:`SCT_LUN_LSB] != 3'h0);
		bad = bad || (cdb_q[5][`SCT_RSV_MSB:`SCT_RSV_LSB] != 4'h0);
	end

	// verdict frozen before the status phase
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bad_q <= 1'b0;
		end else if (st_q == T_ACK && !bus.ack_ini && idx_q == 3'(`SCT_CDB_LEN - 1)) begin
			bad_q <= bad;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q  <= T_IDLE;
			cnt_q <= 18'h0;
			idx_q <= 3'h0;
		end else if (bus.rst) begin
			st_q  <= T_IDLE;
			cnt_q <= 18'h0;
			idx_q <= 3'h0;
		end else begin
			case (st_q)
				T_IDLE: begin
					cnt_q <= 18'h0;
					idx_q <= 3'h0;
					if (sel_seen) begin
						st_q <= T_SETTLE;
					end
				end
				T_SETTLE: begin
					cnt_q <= cnt_q + 18'h1;
					if (!bus.sel && !bus.bsy) begin
						st_q <= T_IDLE;
					end else if (cnt_q >= 18'(ABORT_CYC)) begin
						st_q <= T_IDLE;
					end else if (cnt_q >= 18'(`SCT_SETTLE_CYC) && !bus.sel) begin
						st_q  <= T_REQ;
						cnt_q <= 18'h0;
					end
				end
				T_REQ: begin
					if (bus.ack_ini) begin
						st_q <= T_ACK;
					end
				end
				T_ACK: begin
					if (!bus.ack_ini) begin
						if (idx_q == 3'(`SCT_CDB_LEN - 1)) begin
							st_q <= T_STAT;
						end else begin
							idx_q <= idx_q + 3'h1;
							st_q  <= T_REQ;
						end
					end
				end
				T_STAT: begin
					if (bus.ack_ini) begin
						st_q <= T_STAT_ACK;
					end
				end
				T_STAT_ACK: begin
					if (!bus.ack_ini) begin
						st_q  <= T_CLEAR;
						cnt_q <= 18'h0;
					end
				end
				T_CLEAR: begin
					st_q <= T_IDLE;
				end
				default: st_q <= T_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (st_q == T_REQ && bus.ack_ini) begin
			cdb_q[idx_q] <= bus.db;
		end
	end

	// busy in every state but idle and clear, dropped at once on bus reset and once settle runs past the abort window
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bus.bsy_tgt <= 1'b0;
		end else begin
			bus.bsy_tgt <= (st_q != T_IDLE && st_q != T_CLEAR) && !bus.rst
				&& !(st_q == T_SETTLE && cnt_q >= 18'(ABORT_CYC));
		end
	end

	// request dropped as soon as ack is seen
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bus.req_tgt <= 1'b0;
		end else begin
			bus.req_tgt <= (st_q == T_REQ || st_q == T_STAT) && !bus.ack_ini;
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bus.cd_tgt <= 1'b0;
			bus.io_tgt <= 1'b0;
		end else begin
			bus.cd_tgt <= (st_q != T_IDLE && st_q != T_CLEAR);
			bus.io_tgt <= (st_q == T_STAT || st_q == T_STAT_ACK);
		end
	end

	// status byte stands until the status ack drops, good or check condition
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bus.db_tgt    <= 8'h00;
			bus.db_tgt_oe <= 1'b0;
		end else begin
			bus.db_tgt    <= ((st_q == T_STAT || st_q == T_STAT_ACK) && bad_q) ? `SCT_STAT_CHECK : `SCT_STAT_GOOD;
			bus.db_tgt_oe <= (st_q == T_STAT || st_q == T_STAT_ACK);
		end
	end

	// bad block gives no command strobe
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cmd_valid_o <= 1'b0;
			cmd_bad_o   <= 1'b0;
			cmd_op_o    <= 8'h00;
			cmd_b1_o    <= 8'h00;
			cmd_arg_o   <= 24'h0;
			cmd_link_o  <= 1'b0;
			cmd_flag_o  <= 1'b0;
		end else begin
			cmd_valid_o <= 1'b0;
			cmd_bad_o   <= 1'b0;
			if (st_q == T_STAT && bus.ack_ini) begin
				cmd_valid_o <= !bad_q;
				cmd_bad_o   <= bad_q;
				cmd_op_o    <= cdb_q[0];
				cmd_b1_o    <= cdb_q[1];
				cmd_arg_o   <= {cdb_q[2], cdb_q[3], cdb_q[4]};
				cmd_link_o  <= cdb_q[5][`SCT_LINK_BIT];
				cmd_flag_o  <= cdb_q[5][`SCT_FLAG_BIT];
			end
		end
	end
endmodule
`default_nettype wire

// ==== src/sct_map.svh ====
// Summary of operation
// - wait 2.2 us after BSY before arbitration check
// - release bus within 800 ns
// - wait 800 ns after bus free
// - assert BSY and ID within 1.8 us
// - allow 400 ns settle after control changes
// - hold RST at least 25 us
// - no BSY 200 us after selection
// - wait 250 ms for BSY response
// - clear bus within 1200 ns
// - accept first ten group 0 opcodes
// - accept remaining listed opcodes
// - command block is six bytes
// - invalid field ends command, no medium action
// - byte 0 group code zero, command code; target never checks the group, also takes 3Bh and 3Ch (group 1)
// - byte 5 link bit 0, flag bit 1
`ifndef SCT_MAP_SVH
`define SCT_MAP_SVH
`define SCT_CLK_MHZ        100
`define SCT_ARB_NS         2200
`define SCT_CLEAR_NS       800
`define SCT_FREE_NS        800
`define SCT_SET_NS         1800
`define SCT_SETTLE_NS      400
`define SCT_RST_NS         25000
`define SCT_ABORT_NS       200000
`define SCT_SELTO_MS       250
`define SCT_BUSCLR_NS      1200
`define SCT_ARB_CYC        ((`SCT_ARB_NS * `SCT_CLK_MHZ + 999) / 1000)
`define SCT_CLEAR_CYC      ((`SCT_CLEAR_NS * `SCT_CLK_MHZ) / 1000)
`define SCT_FREE_CYC       ((`SCT_FREE_NS * `SCT_CLK_MHZ + 999) / 1000)
`define SCT_SET_CYC        ((`SCT_SET_NS * `SCT_CLK_MHZ) / 1000)
`define SCT_SETTLE_CYC     ((`SCT_SETTLE_NS * `SCT_CLK_MHZ + 999) / 1000)
`define SCT_RST_CYC        ((`SCT_RST_NS * `SCT_CLK_MHZ + 999) / 1000)
`define SCT_ABORT_CYC      ((`SCT_ABORT_NS * `SCT_CLK_MHZ) / 1000)
`define SCT_SELTO_CYC      (`SCT_SELTO_MS * `SCT_CLK_MHZ * 1000)
`define SCT_BUSCLR_CYC     ((`SCT_BUSCLR_NS * `SCT_CLK_MHZ) / 1000)
`define SCT_CDB_LEN        6
`define SCT_LUN_MSB        7
`define SCT_LUN_LSB        5
`define SCT_GRP_MSB        7
`define SCT_GRP_LSB        5
`define SCT_RSV_MSB        5
`define SCT_RSV_LSB        2
`define SCT_FLAG_BIT       1
`define SCT_LINK_BIT       0
`define SCT_TGT_ID         3'h0
`define SCT_INI_ID         3'h7
`define SCT_STAT_GOOD      8'h00
`define SCT_STAT_CHECK     8'h02
// host register offsets, byte addresses on the avalon slave
`define SCT_REG_CTRL       4'h0
`define SCT_REG_STAT       4'h4
`define SCT_REG_CDB_LO     4'h8
`define SCT_REG_CDB_HI     4'hC
`define SCT_CTRL_GO        0
`define SCT_CTRL_RST       1
`endif

// ==== src/sct_pkg.sv ====
`default_nettype none
package sct_pkg;
	typedef enum logic [1:0] {
		SCT_RES_NONE,
		SCT_RES_OK,
		SCT_RES_BAD,
		SCT_RES_TIMEOUT
	} sct_res_t;
endpackage
`default_nettype wire

// ==== src/sct_bus_if.sv ====
`default_nettype none
interface sct_bus_if;
	// wired-or style bus: busy and data or-ed from both ends, only the data lines driven with an enable
	logic       bsy_ini;
	logic       bsy_tgt;
	logic       sel_ini;
	logic       rst_ini;
	logic       req_tgt;
	logic       ack_ini;
	logic       cd_tgt;
	logic       io_tgt;
	logic [7:0] db_ini;
	logic       db_ini_oe;
	logic [7:0] db_tgt;
	logic       db_tgt_oe;
	logic       bsy;
	logic       sel;
	logic       rst;
	logic [7:0] db;
	assign bsy = bsy_ini | bsy_tgt;
	assign sel = sel_ini;
	assign rst = rst_ini;
	assign db  = (db_ini_oe ? db_ini : 8'h00) | (db_tgt_oe ? db_tgt : 8'h00);
	modport tgt (
		input  bsy, sel, rst, db, ack_ini,
		output bsy_tgt, req_tgt, cd_tgt, io_tgt, db_tgt, db_tgt_oe
	);
	modport ini (
		input  bsy, sel, rst, db, req_tgt, cd_tgt, io_tgt,
		output bsy_ini, sel_ini, rst_ini, ack_ini, db_ini, db_ini_oe
	);
endinterface
`default_nettype wire

// ==== src/sct_initiator.sv ====
`include "sct_map.svh"
`default_nettype none
module sct_initiator
	import sct_pkg::*;
#(
	parameter int SELTO_CYC = `SCT_SELTO_CYC,
	parameter int RST_CYC   = `SCT_RST_CYC
) (
	// clock and reset
	input  wire logic        clk_i,
	input  wire logic        rst_b_i,
	// avalon-mm slave
	input  wire logic [3:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic [31:0]      avs_readdata,
	output logic             avs_waitrequest,
	// bus
	sct_bus_if.ini           bus
);
	typedef enum logic [3:0] {I_IDLE, I_RST, I_FREE, I_ARB, I_SEL, I_WAIT, I_SEND, I_SACK, I_STAT, I_DONE} sct_ist_t;
	sct_ist_t    st_q;
	logic [31:0] cnt_q;
	logic [2:0]  idx_q;
	logic [47:0] cdb_q;
	logic [7:0]  stat_q;
	sct_res_t    res_q;
	logic        go;
	logic        rst_req;

	assign go      = avs_write && !avs_waitrequest && avs_address == `SCT_REG_CTRL && avs_writedata[`SCT_CTRL_GO];
	assign rst_req = avs_write && !avs_waitrequest && avs_address == `SCT_REG_CTRL && avs_writedata[`SCT_CTRL_RST];

	// one wait cycle per access, answer on second edge
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			avs_waitrequest <= 1'b1;
			avs_readdata    <= 32'h0;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
			if (avs_read && avs_waitrequest) begin
				case (avs_address)
					`SCT_REG_STAT:   avs_readdata <= {20'h0, stat_q, (st_q == I_IDLE), 1'b0, res_q};
					`SCT_REG_CDB_LO: avs_readdata <= cdb_q[31:0];
					`SCT_REG_CDB_HI: avs_readdata <= {16'h0, cdb_q[47:32]};
					default:         avs_readdata <= 32'h0;
				endcase
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			cdb_q <= 48'h0;
		end else if (avs_write && !avs_waitrequest && st_q == I_IDLE) begin
			if (avs_address == `SCT_REG_CDB_LO) cdb_q[31:0] <= avs_writedata;
			if (avs_address == `SCT_REG_CDB_HI) cdb_q[47:32] <= avs_writedata[15:0];
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			st_q   <= I_IDLE;
			cnt_q  <= 32'h0;
			idx_q  <= 3'h0;
			stat_q <= 8'h00;
			res_q  <= SCT_RES_NONE;
		end else begin
			cnt_q <= cnt_q + 32'h1;
			case (st_q)
				I_IDLE: begin
					cnt_q <= 32'h0;
					idx_q <= 3'h0;
					if (rst_req) st_q <= I_RST;
					else if (go) begin
						st_q  <= I_FREE;
						res_q <= SCT_RES_NONE;
					end
				end
				I_RST: if (cnt_q >= 32'(RST_CYC - 1)) st_q <= I_IDLE;
				I_FREE: begin
					if (bus.bsy || bus.sel) cnt_q <= 32'h0;
					else if (cnt_q >= 32'(`SCT_FREE_CYC)) begin
						st_q  <= I_ARB;
						cnt_q <= 32'h0;
					end
				end
				I_ARB: begin
					// arbitration delay; set within bus set
					if (cnt_q >= 32'(`SCT_ARB_CYC)) begin
						st_q  <= I_SEL;
						cnt_q <= 32'h0;
					end
				end
				I_SEL: begin
					if (cnt_q >= 32'(`SCT_SETTLE_CYC)) begin
						st_q  <= I_WAIT;
						cnt_q <= 32'h0;
					end
				end
				I_WAIT: begin
					if (bus.bsy) st_q <= I_SEND;
					else if (cnt_q >= 32'(SELTO_CYC)) begin
						st_q  <= I_DONE;
						res_q <= SCT_RES_TIMEOUT;
					end
				end
				I_SEND: begin
					if (bus.req_tgt && bus.io_tgt) st_q <= I_STAT;
					else if (bus.req_tgt) st_q <= I_SACK;
					else if (!bus.bsy) st_q <= I_DONE;
				end
				I_SACK: if (!bus.req_tgt) begin
					idx_q <= idx_q + 3'h1;
					st_q  <= I_SEND;
				end
				I_STAT: if (!bus.req_tgt) begin
					stat_q <= bus.db;
					res_q  <= (bus.db == `SCT_STAT_GOOD) ? SCT_RES_OK : SCT_RES_BAD;
					st_q   <= I_DONE;
				end
				I_DONE: begin
					st_q <= I_IDLE;
				end
				default: st_q <= I_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			bus.bsy_ini   <= 1'b0;
			bus.sel_ini   <= 1'b0;
			bus.rst_ini   <= 1'b0;
			bus.ack_ini   <= 1'b0;
			bus.db_ini    <= 8'h00;
			bus.db_ini_oe <= 1'b0;
		end else begin
			bus.rst_ini   <= (st_q == I_RST);
			bus.bsy_ini   <= (st_q == I_ARB) || (st_q == I_SEL && cnt_q < 32'(`SCT_SETTLE_CYC - 1));
			bus.sel_ini   <= (st_q == I_SEL) || (st_q == I_WAIT && !bus.bsy);
			bus.ack_ini   <= (st_q == I_SACK || st_q == I_STAT) && bus.req_tgt;
			// command bytes only while one is left, so the status byte never meets a second driver
			bus.db_ini_oe <= (st_q == I_ARB || st_q == I_SEL || st_q == I_WAIT)
				|| ((st_q == I_SEND || st_q == I_SACK) && idx_q < 3'(`SCT_CDB_LEN));
			if (st_q == I_ARB) bus.db_ini <= 8'h01 << `SCT_INI_ID;
			else if (st_q == I_SEL || st_q == I_WAIT)
				bus.db_ini <= (8'h01 << `SCT_INI_ID) | (8'h01 << `SCT_TGT_ID);
			else if (idx_q < 3'(`SCT_CDB_LEN)) bus.db_ini <= cdb_q[8*idx_q +: 8];
			else bus.db_ini <= 8'h00;
		end
	end
endmodule
`default_nettype wire

// ==== test/sct_monitor.sv ====
`include "sct_map.svh"
`default_nettype none
module sct_monitor #(
	parameter int RST_CYC   = 50,
	parameter int ABORT_CYC = 500
) (
	// clock and reset
	input wire logic       clk_i,
	input wire logic       rst_b_i,
	// initiator drives
	input wire logic       bsy_ini,
	input wire logic       sel_ini,
	input wire logic       rst_ini,
	input wire logic [7:0] db_ini,
	input wire logic       db_ini_oe,
	// target drives
	input wire logic       bsy_tgt,
	input wire logic       req_tgt,
	input wire logic       cd_tgt,
	input wire logic       io_tgt,
	input wire logic       db_tgt_oe,
	// resolved lines
	input wire logic       bsy,
	input wire logic       sel,
	input wire logic [7:0] db
);
	timeunit 1ns;
	timeprecision 1ns;
	localparam int ARB_CYC    = `SCT_ARB_CYC;
	localparam int FREE_CYC   = `SCT_FREE_CYC;
	localparam int CLEAR_CYC  = `SCT_BUSCLR_CYC;
	localparam int SETTLE_CYC = `SCT_SETTLE_CYC;
	logic [15:0] free_q, arb_q, hold_q, gap_q;
	logic [3:0]  byte_q;
	default clocking mon_cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_b_i);
	// the 16-bit counters saturate so a long idle bus never wraps back under a limit
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) free_q <= 16'h0000;
		else free_q <= (bsy || sel) ? 16'h0000 : free_q + {15'h0000, ~&free_q};
	end
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) arb_q <= 16'h0000;
		else arb_q <= (bsy_ini && !sel_ini) ? arb_q + {15'h0000, ~&arb_q} : 16'h0000;
	end
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) hold_q <= 16'h0000;
		else hold_q <= rst_ini ? hold_q + {15'h0000, ~&hold_q} : 16'h0000;
	end
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) gap_q <= 16'h0000;
		else gap_q <= sel ? 16'h0000 : gap_q + {15'h0000, ~&gap_q};
	end
	always_ff @(posedge clk_i or negedge rst_b_i) begin
		if (!rst_b_i) byte_q <= 4'h0;
		else if (sel) byte_q <= 4'h0;
		else if ($rose(req_tgt) && cd_tgt && !io_tgt) byte_q <= byte_q + 4'h1;
	end
	a_arb_delay: assert property ($rose(sel_ini) |-> arb_q >= ARB_CYC)
		else $error("selection before arbitration delay");
	a_bus_clear: assert property (free_q >= CLEAR_CYC |-> !(db_tgt_oe || req_tgt || cd_tgt || io_tgt))
		else $error("target still drives a free bus");
	a_free_delay: assert property ($rose(bsy_ini) |-> free_q >= FREE_CYC)
		else $error("arbitration too soon after bus free");
	a_arb_id: assert property ($rose(bsy_ini) |-> db_ini_oe && db_ini[`SCT_INI_ID])
		else $error("busy raised without own id bit");
	a_req_settle: assert property ($rose(req_tgt) |-> gap_q >= SETTLE_CYC)
		else $error("request before settle time");
	a_rst_hold: assert property ($fell(rst_ini) |-> hold_q >= RST_CYC)
		else $error("bus reset released too early");
	a_sel_abort: assert property ($rose(bsy_tgt) |-> gap_q <= ABORT_CYC && db[`SCT_TGT_ID])
		else $error("target answered a stale selection");
	a_cdb_six: assert property ($rose(io_tgt) |-> byte_q == 4'h6)
		else $error("command block not six bytes");
endmodule
`default_nettype wire

// ==== test/tb.sv ====
`include "sct_map.svh"
`default_nettype none
module tb
	import sct_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	localparam int SELTO = 2000;
	localparam int RSTC  = 50;
	localparam int ABRT  = 500;
	localparam logic [7:0] OPS [24] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h05, 8'h08, 8'h0A, 8'h0C, 8'h10, 8'h11,
		8'h12, 8'h13, 8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1D, 8'h1E, 8'h3B, 8'h3C};
	// invalid blocks as opcode, byte 1, byte 5
	localparam logic [23:0] BAD [6] = '{24'h040000, 24'h200000, 24'h1C0000, 24'h002000, 24'h010004, 24'h080020};
	logic        clk_i, rst_b_i, cmd_valid, cmd_bad, cmd_link, cmd_flag;
	logic [3:0]  avs_address;
	logic [31:0] avs_writedata, stat, junk;
	logic [1:0]  avs_rd, avs_wr;
	logic        wreq [2];
	logic [31:0] rdata [2];
	logic [7:0]  cmd_op, cmd_b1;
	logic [23:0] cmd_arg;
	int          num_errors, checks, cyc, nv, nb, rst_seen, t0;
	sct_bus_if bus_a ();
	sct_bus_if bus_b ();
	sct_target #(.ABORT_CYC(ABRT)) i_sct_target (.clk_i(clk_i), .rst_b_i(rst_b_i), .bus(bus_a),
		.cmd_valid_o(cmd_valid), .cmd_op_o(cmd_op), .cmd_b1_o(cmd_b1), .cmd_arg_o(cmd_arg),
		.cmd_link_o(cmd_link), .cmd_flag_o(cmd_flag), .cmd_bad_o(cmd_bad));
	sct_initiator #(.SELTO_CYC(SELTO), .RST_CYC(RSTC)) i_sct_initiator (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.avs_address(avs_address), .avs_read(avs_rd[0]), .avs_write(avs_wr[0]), .avs_writedata(avs_writedata),
		.avs_readdata(rdata[0]), .avs_waitrequest(wreq[0]), .bus(bus_a));
	// lone initiator: nobody answers its selection
	sct_initiator #(.SELTO_CYC(SELTO), .RST_CYC(RSTC)) i_sct_initiator_b (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.avs_address(avs_address), .avs_read(avs_rd[1]), .avs_write(avs_wr[1]), .avs_writedata(avs_writedata),
		.avs_readdata(rdata[1]), .avs_waitrequest(wreq[1]), .bus(bus_b));
	sct_monitor #(.RST_CYC(RSTC), .ABORT_CYC(ABRT)) i_sct_monitor (.clk_i(clk_i), .rst_b_i(rst_b_i),
		.bsy_ini(bus_a.bsy_ini), .sel_ini(bus_a.sel_ini), .rst_ini(bus_a.rst_ini), .db_ini(bus_a.db_ini),
		.db_ini_oe(bus_a.db_ini_oe), .bsy_tgt(bus_a.bsy_tgt), .req_tgt(bus_a.req_tgt), .cd_tgt(bus_a.cd_tgt),
		.io_tgt(bus_a.io_tgt), .db_tgt_oe(bus_a.db_tgt_oe), .bsy(bus_a.bsy), .sel(bus_a.sel), .db(bus_a.db));
	always #5 clk_i = ~clk_i;
	// released data lines wander so a stale value is never mistaken for a drive
	always @(posedge clk_i) begin
		bus_b.db_tgt <= bus_b.db_tgt + 8'h01;
		cyc <= cyc + 1;
		nv <= nv + int'(cmd_valid === 1'b1);
		nb <= nb + int'(cmd_bad === 1'b1);
		rst_seen <= rst_seen + int'(bus_a.rst === 1'b1);
		if (cyc == 90000) begin
			num_errors++;
			close_out();
		end
	end
	task close_out();
		if (num_errors == 0 && checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask
	task xfer(input int k, input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		avs_address <= a;
		avs_writedata <= d;
		avs_rd[k] <= !w;
		avs_wr[k] <= w;
		do @(posedge clk_i);
		while (wreq[k] !== 1'b0);
		q = rdata[k];
		avs_rd[k] <= 1'b0;
		avs_wr[k] <= 1'b0;
	endtask
	task wait_idle(input int k);
		do xfer(k, 1'b0, `SCT_REG_STAT, 32'h0, stat);
		while (stat[3] !== 1'b1);
	endtask
	task run(input logic [7:0] op, input logic [7:0] b1, input logic [7:0] x, input logic [7:0] y,
		input logic [7:0] b5);
		logic ok;
		int   nv0, nb0;
		ok = 1'b0;
		foreach (OPS[i]) ok |= OPS[i] == op;
		ok &= b1[7:5] == 3'h0 && b5[5:2] == 4'h0;
		nv0 = nv;
		nb0 = nb;
		xfer(0, 1'b1, `SCT_REG_CDB_LO, {y, x, b1, op}, junk);
		xfer(0, 1'b1, `SCT_REG_CDB_HI, {16'h0000, b5, x}, junk);
		xfer(0, 1'b1, `SCT_REG_CTRL, 32'h0000_0001, junk);
		// a block written while busy must be ignored
		xfer(0, 1'b1, `SCT_REG_CDB_LO, ~{y, x, b1, op}, junk);
		wait_idle(0);
		chk("result", {30'h0, stat[1:0]}, {30'h0, ok ? SCT_RES_OK : SCT_RES_BAD});
		chk("status", {24'h0, stat[11:4]}, ok ? 32'h0000_0000 : 32'h0000_0002);
		chk("valid", nv - nv0, {31'h0, ok});
		chk("bad", nb - nb0, {31'h0, !ok});
		if (ok) begin
			chk("op", {24'h0, cmd_op}, {24'h0, op});
			chk("bytes", {cmd_b1, cmd_arg}, {b1, x, y, x});
			chk("flag_link", {30'h0, cmd_flag, cmd_link}, {30'h0, b5[1:0]});
		end
	endtask
	initial begin
		clk_i = 1'b0;
		rst_b_i = 1'b0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		avs_rd = 2'h0;
		avs_wr = 2'h0;
		{bus_b.bsy_tgt, bus_b.req_tgt, bus_b.cd_tgt, bus_b.io_tgt, bus_b.db_tgt_oe} = 5'h00;
		bus_b.db_tgt = 8'h00;
		repeat (12) @(posedge clk_i);
		rst_b_i <= 1'b1;
		xfer(0, 1'b0, `SCT_REG_STAT, 32'h0, stat);
		chk("stat_rst", stat, 32'h0000_0008);
		xfer(0, 1'b0, 4'h2, 32'h0, junk);
		chk("unmapped", junk, 32'h0);
		chk("tgt_rst", {14'h0, cmd_op, cmd_b1, cmd_flag, cmd_link}, 32'h0);
		for (int i = 0; i < 24; i++) begin
			run(OPS[i], {3'h0, 5'(i)}, 8'(i * 7), 8'h5A ^ 8'(i), {2'(i), 4'h0, 2'(i)});
		end
		foreach (BAD[i]) begin
			run(BAD[i][23:16], BAD[i][15:8], 8'h00, 8'h00, BAD[i][7:0]);
		end
		xfer(0, 1'b1, `SCT_REG_CTRL, 32'h0000_0002, junk);
		while (rst_seen == 0 || bus_a.rst === 1'b1) @(posedge clk_i);
		chk("rst_hold", {31'h0, rst_seen >= RSTC}, 32'h1);
		run(8'h0A, 8'h00, 8'h11, 8'h22, 8'h01);
		xfer(1, 1'b1, `SCT_REG_CTRL, 32'h0000_0001, junk);
		t0 = cyc;
		wait_idle(1);
		chk("sel_timeout", {30'h0, stat[1:0]}, {30'h0, SCT_RES_TIMEOUT});
		chk("sel_wait", {31'h0, cyc - t0 >= SELTO}, 32'h1);
		chk("released", {30'h0, bus_b.sel, bus_b.bsy}, 32'h0);
		close_out();
	end
endmodule
`default_nettype wire
